// *** rtl/synth_cal_pkg.sv ***
// constants for the synthesizer output and calibration register slice
package synth_cal_pkg;

    localparam int ADDR_W = 7;
    localparam int DATA_W = 16;
    localparam int CMD_BITS = 8;
    localparam int FRAME_BITS = 24;
    localparam logic [4:0] CMD_BITS_5 = 5'h08;
    localparam logic [4:0] FRAME_BITS_5 = 5'h18;

    // register addresses
    localparam logic [6:0] OUTPUT_LEVEL_SHUTDOWN_MODULATOR = 7'h2e;
    localparam logic [6:0] OUTPUT_A_SOURCE_B_LEVEL = 7'h2f;
    localparam logic [6:0] OUTPUT_B_SOURCE = 7'h30;
    localparam logic [6:0] STATUS_PIN_DRIVE = 7'h3b;
    localparam logic [6:0] LOCK_INDICATOR_CONFIG = 7'h3d;
    localparam logic [6:0] DEFAULT_FILL_CONFIG = 7'h3e;
    localparam logic [6:0] FAST_CALIBRATION_CONFIG = 7'h40;
    localparam logic [6:0] LOCK_AND_CORE_READBACK = 7'h44;
    localparam logic [6:0] CAPACITOR_CODE_READBACK = 7'h45;
    localparam logic [6:0] DAC_CURRENT_READBACK = 7'h46;

    // storage slots of the writable words
    localparam int NUM_CFG = 7;
    localparam logic [2:0] SLOT_LEVEL = 3'h0;
    localparam logic [2:0] SLOT_A_SRC = 3'h1;
    localparam logic [2:0] SLOT_B_SRC = 3'h2;
    localparam logic [2:0] SLOT_DRIVE = 3'h3;
    localparam logic [2:0] SLOT_LOCK_CFG = 3'h4;
    localparam logic [2:0] SLOT_FILL = 3'h5;
    localparam logic [2:0] SLOT_FAST_CAL = 3'h6;

    // field positions (low bit)
    localparam int OUT_A_LEVEL_LSB = 8;
    localparam int OUT_B_SHUTDOWN_POS = 7;
    localparam int OUT_A_SHUTDOWN_POS = 6;
    localparam int MODULATOR_ORDER_LSB = 0;
    localparam int OUT_A_SOURCE_LSB = 11;
    localparam int OUT_B_LEVEL_LSB = 0;
    localparam int OUT_B_SOURCE_LSB = 0;
    localparam int HIGH_DRIVE_POS = 5;
    localparam int LOCK_TYPE_POS = 0;
    localparam int QUICK_AMP_POS = 9;
    localparam int QUICK_FREQ_POS = 8;
    localparam int AMP_STEP_LSB = 5;
    localparam int FREQ_STEP_LSB = 0;
    localparam int TUNING_LOCK_LSB = 9;
    localparam int CORE_CHOICE_LSB = 5;

    // tuning lock readback code meaning locked
    localparam logic [1:0] TUNING_LOCKED = 2'h2;

    // whole-word reset values
    localparam logic [15:0] RST_LEVEL = 16'h0f80;
    localparam logic [15:0] RST_A_SRC = 16'h0000;
    localparam logic [15:0] RST_B_SRC = 16'h0000;
    localparam logic [15:0] RST_DRIVE = 16'h0000;
    localparam logic [15:0] RST_LOCK_CFG = 16'h0001;
    localparam logic [15:0] RST_FILL = 16'h0000;
    localparam logic [15:0] RST_FAST_CAL = 16'h006f;

    typedef enum logic [2:0] {
        SER_IDLE = 3'b001,
        SER_CMD = 3'b010,
        SER_DATA = 3'b100
    } ser_state_t;

endpackage

// *** rtl/synth_output_cal_regs.sv ***
// serial-programmed output, modulator and calibration register slice
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - output A level in bits 13:8, reset 15, codes up to 63
// - output B level in bits 5:0, reset zero
// - bit 7 powers down output B buffer, resets to one
// - bit 6 powers down output A buffer, resets to zero
// - modulator order 0 is integer mode, 1 to 4 select order
// - source 0 routes channel divider, 1 the oscillator; host avoids 2, 3
// - high-drive bit 5 strengthens the status pin, resets to zero
// - type zero: status pin high once calibration succeeded
// - type one: status pin high while tuning voltage is locked
// - bit 9 enables quick amplitude cal, bit 8 quick frequency cal
// - amplitude step bits 7:5, reset 3, used while quick amplitude on
// - frequency step bits 3:0, reset 15, used while quick frequency on
// - tuning lock state read back in bits 10:9
// - chosen oscillator core read back in bits 7:5
// - chosen capacitor code read back in bits 7:0
// - chosen dac current code read back in bits 8:0
module synth_output_cal_regs (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ser_clk_i,
    input wire logic ser_sel_n_i,
    input wire logic ser_data_i,
    output logic ser_data_o,
    input wire logic status_pin_select_i,
    input wire logic cal_done_i,
    input wire logic [1:0] tuning_lock_i,
    input wire logic [2:0] core_choice_i,
    input wire logic [7:0] capacitor_code_i,
    input wire logic [8:0] dac_current_i,
    output logic [5:0] out_a_level_o,
    output logic [5:0] out_b_level_o,
    output logic out_a_shutdown_o,
    output logic out_b_shutdown_o,
    output logic [1:0] out_a_source_o,
    output logic [1:0] out_b_source_o,
    output logic integer_mode_o,
    output logic [3:0] modulator_order_o,
    output logic status_pin_high_drive_o,
    output logic status_pin_o,
    output logic quick_amplitude_cal_en_o,
    output logic quick_frequency_cal_en_o,
    output logic [2:0] amplitude_step_o,
    output logic [3:0] frequency_step_o
);
    import synth_cal_pkg::*;
    // bit 3 set means no writable word lives at this address
    function automatic logic [3:0] slot_of(input logic [6:0] addr);
        unique case (addr)
            OUTPUT_LEVEL_SHUTDOWN_MODULATOR: return {1'b0, SLOT_LEVEL};
            OUTPUT_A_SOURCE_B_LEVEL: return {1'b0, SLOT_A_SRC};
            OUTPUT_B_SOURCE: return {1'b0, SLOT_B_SRC};
            STATUS_PIN_DRIVE: return {1'b0, SLOT_DRIVE};
            LOCK_INDICATOR_CONFIG: return {1'b0, SLOT_LOCK_CFG};
            DEFAULT_FILL_CONFIG: return {1'b0, SLOT_FILL};
            FAST_CALIBRATION_CONFIG: return {1'b0, SLOT_FAST_CAL};
            default: return 4'h8;
        endcase
    endfunction
    // serial port state
    ser_state_t state;
    ser_state_t next_state;
    logic sck_q;
    logic sel_n_q;
    logic [4:0] bit_cnt;
    logic [4:0] next_bit_cnt;
    logic [23:0] shift_in;
    logic [23:0] next_shift_in;
    logic [15:0] shift_out;
    logic [15:0] next_shift_out;
    logic sdo;
    logic next_sdo;
    // configuration words and readback words
    logic [15:0] cfg [NUM_CFG];
    logic [15:0] next_cfg [NUM_CFG];
    logic [15:0] rb_lock_core;
    logic [15:0] rb_cap;
    logic [15:0] rb_dac;
    // registered outputs, then combinational edge, frame and address decode signals
    logic status_pin;
    logic next_status_pin;
    logic integer_mode;
    logic next_integer_mode;
    logic [3:0] mod_order;
    logic [3:0] next_mod_order;
    logic [2:0] amp_step;
    logic [2:0] next_amp_step;
    logic [3:0] freq_step;
    logic [3:0] next_freq_step;
    logic sck_rise;
    logic sck_fall;
    logic frame_end;
    logic [3:0] wr_slot;
    logic [3:0] rd_slot;
    logic [15:0] read_word;
    // port pins are treated as synchronous, so one stage of history suffices
    assign sck_rise = ser_clk_i & ~sck_q;
    assign sck_fall = ~ser_clk_i & sck_q;
    assign frame_end = ser_sel_n_i & ~sel_n_q;
    assign wr_slot = slot_of(shift_in[22:16]);
    assign rd_slot = slot_of(next_shift_in[6:0]);

    always_comb
    begin
        read_word = 16'h0000;
        unique case (next_shift_in[6:0])
            LOCK_AND_CORE_READBACK: read_word = rb_lock_core;
            CAPACITOR_CODE_READBACK: read_word = rb_cap;
            DAC_CURRENT_READBACK: read_word = rb_dac;
            default:
            begin
                if (!rd_slot[3])
                begin
                    read_word = cfg[rd_slot[2:0]];
                end
            end
        endcase
    end

    // frame: read flag, 7 address bits, 16 data bits, msb first
    always_comb
    begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shift_in = shift_in;
        next_shift_out = shift_out;
        next_sdo = sdo;
        unique case (state)
            SER_IDLE:
            begin
                next_bit_cnt = 5'h00;
                next_sdo = 1'b0;
                if (!ser_sel_n_i)
                begin
                    next_state = SER_CMD;
                end
            end
            SER_CMD:
            begin
                if (ser_sel_n_i)
                begin
                    next_state = SER_IDLE;
                end
                else if (sck_rise)
                begin
                    next_shift_in = {shift_in[22:0], ser_data_i};
                    next_bit_cnt = bit_cnt + 5'h01;
                    if (next_bit_cnt == CMD_BITS_5)
                    begin
                        next_state = SER_DATA;
                        next_shift_out = read_word;
                    end
                end
            end
            SER_DATA:
            begin
                if (ser_sel_n_i)
                begin
                    next_state = SER_IDLE;
                end
                else
                begin
                    if (sck_rise && bit_cnt != FRAME_BITS_5)
                    begin
                        next_shift_in = {shift_in[22:0], ser_data_i};
                        next_bit_cnt = bit_cnt + 5'h01;
                    end
                    // read flag drifts up as data bits shift in, so follow the count
                    if (sck_fall && shift_in[bit_cnt - 5'h01])
                    begin
                        next_sdo = shift_out[15];
                        next_shift_out = {shift_out[14:0], 1'b0};
                    end
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            state <= SER_IDLE;
            sck_q <= 1'b0;
            sel_n_q <= 1'b1;
            bit_cnt <= 5'h00;
            shift_in <= 24'h000000;
            shift_out <= 16'h0000;
            sdo <= 1'b0;
        end
        else
        begin
            state <= next_state;
            sck_q <= ser_clk_i;
            sel_n_q <= ser_sel_n_i;
            bit_cnt <= next_bit_cnt;
            shift_in <= next_shift_in;
            shift_out <= next_shift_out;
            sdo <= next_sdo;
        end
    end

    // a write lands only when the frame closes complete
    always_comb
    begin
        for (int i = 0; i < NUM_CFG; i++)
        begin
            next_cfg[i] = cfg[i];
        end
        if (frame_end && bit_cnt == FRAME_BITS_5 && !shift_in[23] && !wr_slot[3])
        begin
            next_cfg[wr_slot[2:0]] = shift_in[15:0];
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            cfg[SLOT_LEVEL] <= RST_LEVEL;
            cfg[SLOT_A_SRC] <= RST_A_SRC;
            cfg[SLOT_B_SRC] <= RST_B_SRC;
            cfg[SLOT_DRIVE] <= RST_DRIVE;
            cfg[SLOT_LOCK_CFG] <= RST_LOCK_CFG;
            cfg[SLOT_FILL] <= RST_FILL;
            cfg[SLOT_FAST_CAL] <= RST_FAST_CAL;
        end
        else
        begin
            cfg <= next_cfg;
        end
    end

    // output decode and status pin
    always_comb
    begin
        next_integer_mode = (cfg[SLOT_LEVEL][MODULATOR_ORDER_LSB +: 3] == 3'h0);
        next_mod_order = 4'h0;
        unique case (cfg[SLOT_LEVEL][MODULATOR_ORDER_LSB +: 3])
            3'h1: next_mod_order = 4'h1;
            3'h2: next_mod_order = 4'h2;
            3'h3: next_mod_order = 4'h4;
            3'h4: next_mod_order = 4'h8;
            default: next_mod_order = 4'h0;
        endcase
        next_amp_step = cfg[SLOT_FAST_CAL][QUICK_AMP_POS] ?
            cfg[SLOT_FAST_CAL][AMP_STEP_LSB +: 3] : 3'h0;
        next_freq_step = cfg[SLOT_FAST_CAL][QUICK_FREQ_POS] ?
            cfg[SLOT_FAST_CAL][FREQ_STEP_LSB +: 4] : 4'h0;
        // lock indication on the status pin
        next_status_pin = 1'b0;
        if (status_pin_select_i)
        begin
            if (cfg[SLOT_LOCK_CFG][LOCK_TYPE_POS])
            begin
                next_status_pin = (tuning_lock_i == TUNING_LOCKED);
            end
            else
            begin
                next_status_pin = cal_done_i;
            end
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            status_pin <= 1'b0;
            integer_mode <= 1'b1;
            mod_order <= 4'h0;
            amp_step <= 3'h0;
            freq_step <= 4'h0;
            rb_lock_core <= 16'h0000;
            rb_cap <= 16'h0000;
            rb_dac <= 16'h0000;
        end
        else
        begin
            status_pin <= next_status_pin;
            integer_mode <= next_integer_mode;
            mod_order <= next_mod_order;
            amp_step <= next_amp_step;
            freq_step <= next_freq_step;
            rb_lock_core <= {5'h00, tuning_lock_i, 1'b0, core_choice_i, 5'h00};
            rb_cap <= {8'h00, capacitor_code_i};
            rb_dac <= {7'h00, dac_current_i};
        end
    end

    assign ser_data_o = sdo;
    assign out_a_level_o = cfg[SLOT_LEVEL][OUT_A_LEVEL_LSB +: 6];
    assign out_b_level_o = cfg[SLOT_A_SRC][OUT_B_LEVEL_LSB +: 6];
    assign out_b_shutdown_o = cfg[SLOT_LEVEL][OUT_B_SHUTDOWN_POS];
    assign out_a_shutdown_o = cfg[SLOT_LEVEL][OUT_A_SHUTDOWN_POS];
    assign out_a_source_o = cfg[SLOT_A_SRC][OUT_A_SOURCE_LSB +: 2];
    assign out_b_source_o = cfg[SLOT_B_SRC][OUT_B_SOURCE_LSB +: 2];
    assign status_pin_high_drive_o = cfg[SLOT_DRIVE][HIGH_DRIVE_POS];
    assign quick_amplitude_cal_en_o = cfg[SLOT_FAST_CAL][QUICK_AMP_POS];
    assign quick_frequency_cal_en_o = cfg[SLOT_FAST_CAL][QUICK_FREQ_POS];
    assign integer_mode_o = integer_mode;
    assign modulator_order_o = mod_order;
    assign status_pin_o = status_pin;
    assign amplitude_step_o = amp_step;
    assign frequency_step_o = freq_step;

    // checks
    a_reset_defaults: assert property (@(posedge sys_clk_i)
        !rst_i && $past(rst_i) |-> out_a_level_o == 6'h0f && out_b_shutdown_o && !out_a_shutdown_o)
        else $error("level or shutdown default wrong");
    a_b_level_reset: assert property (@(posedge sys_clk_i)
        !rst_i && $past(rst_i) |-> out_b_level_o == 6'h00 && out_b_source_o == 2'h0)
        else $error("output b default wrong");
    a_step_defaults: assert property (@(posedge sys_clk_i)
        !rst_i && $past(rst_i) |-> cfg[SLOT_FAST_CAL][7:5] == 3'h3 && cfg[SLOT_FAST_CAL][3:0] == 4'hf)
        else $error("step defaults wrong");
    a_integer_mode: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $changed(cfg[SLOT_LEVEL][2:0]) |=> integer_mode_o == (cfg[SLOT_LEVEL][2:0] == 3'h0))
        else $error("integer mode decode wrong");
    a_freq_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !quick_frequency_cal_en_o ##1 !quick_frequency_cal_en_o |-> frequency_step_o == 4'h0)
        else $error("frequency step not gated");
    a_amp_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        quick_amplitude_cal_en_o ##1 quick_amplitude_cal_en_o
        |-> amplitude_step_o == $past(cfg[SLOT_FAST_CAL][7:5]))
        else $error("amplitude step not passed");
    a_cal_status: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        status_pin_select_i && cal_done_i && !cfg[SLOT_LOCK_CFG][0] |=> status_pin_o)
        else $error("calibration status not shown");
    a_vtune_status: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        status_pin_select_i && cfg[SLOT_LOCK_CFG][0] |=> status_pin_o == ($past(tuning_lock_i) == 2'h2))
        else $error("tuning lock status wrong");
    a_readback_track: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        1'b1 |=> rb_dac[8:0] == $past(dac_current_i) && rb_cap[7:0] == $past(capacitor_code_i))
        else $error("readback not tracking");
    a_core_field: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        1'b1 |=> rb_lock_core[7:5] == $past(core_choice_i) && rb_lock_core[10:9] == $past(tuning_lock_i))
        else $error("lock and core readback misplaced");
    a_cfg_stable: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !frame_end |=> $stable(cfg[SLOT_FAST_CAL]) && $stable(cfg[SLOT_LEVEL]))
        else $error("configuration changed outside a frame end");
    c_write_frame: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        frame_end && bit_cnt == FRAME_BITS_5 && !shift_in[23]);
    c_read_frame: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        state == SER_DATA && shift_in[bit_cnt - 5'h01] && sck_fall);
    c_lock_shown: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        status_pin_o && cfg[SLOT_LOCK_CFG][0]);

endmodule
`default_nettype wire

// *** testbench/serial_host_model.sv ***
// host controller model driving the serial programming port
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
    input wire logic sys_clk_i,
    input wire logic ser_data_i,
    output var logic ser_clk_o,
    output var logic ser_sel_n_o,
    output var logic ser_data_o
);
    // three system clocks per phase, above the two-clock minimum
    localparam int HALF = 3;

    initial
    begin
        ser_clk_o = 1'b0;
        ser_sel_n_o = 1'b1;
        ser_data_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    // msb first; read bits sampled just before each rise, last 16 kept
    task automatic xfer(input logic [23:0] word, input int nbits, output logic [15:0] rd);
        rd = 16'h0000;
        tick(1);
        ser_sel_n_o = 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            ser_data_o = word[23 - i];
            tick(HALF);
            rd = {rd[14:0], ser_data_i};
            ser_clk_o = 1'b1;
            tick(HALF);
            ser_clk_o = 1'b0;
        end
        tick(HALF);
        ser_sel_n_o = 1'b1;
        // released line must not keep showing the last bit
        ser_data_o = ~ser_data_o;
        tick(HALF);
    endtask
endmodule
`default_nettype wire

// *** testbench/tb_synth_output_cal_regs.sv ***
// self-checking bench for the output and calibration register slice
`timescale 1ns/1ps
`default_nettype none
module tb_synth_output_cal_regs;
    import synth_cal_pkg::*;

    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic ser_clk, ser_sel_n, ser_mosi, ser_miso;
    logic status_pin_select = 1'b0;
    logic cal_done = 1'b0;
    logic [1:0] tuning_lock = 2'h0;
    logic [2:0] core_choice = 3'h1;
    logic [7:0] capacitor_code = 8'h00;
    logic [8:0] dac_current = 9'h000;
    logic [5:0] out_a_level, out_b_level;
    logic out_a_shutdown, out_b_shutdown, integer_mode, high_drive, status_pin;
    logic [1:0] out_a_source, out_b_source;
    logic [3:0] modulator_order, frequency_step;
    logic quick_amp, quick_freq;
    logic [2:0] amplitude_step;
    logic [3:0] exp_ord;
    int fail_count = 0;
    int cmp_count = 0;
    logic [6:0] rst_addr [7] = '{OUTPUT_LEVEL_SHUTDOWN_MODULATOR, OUTPUT_A_SOURCE_B_LEVEL,
        OUTPUT_B_SOURCE, STATUS_PIN_DRIVE, LOCK_INDICATOR_CONFIG, DEFAULT_FILL_CONFIG,
        FAST_CALIBRATION_CONFIG};
    logic [15:0] rst_word [7] = '{16'h0f80, 16'h0000, 16'h0000, 16'h0000, 16'h0001,
        16'h0000, 16'h006f};

    always #2 sys_clk = ~sys_clk;

    serial_host_model host (
        .sys_clk_i(sys_clk),
        .ser_data_i(ser_miso),
        .ser_clk_o(ser_clk),
        .ser_sel_n_o(ser_sel_n),
        .ser_data_o(ser_mosi)
    );

    synth_output_cal_regs DUT (
        .sys_clk_i(sys_clk),
        .rst_i(rst),
        .ser_clk_i(ser_clk),
        .ser_sel_n_i(ser_sel_n),
        .ser_data_i(ser_mosi),
        .ser_data_o(ser_miso),
        .status_pin_select_i(status_pin_select),
        .cal_done_i(cal_done),
        .tuning_lock_i(tuning_lock),
        .core_choice_i(core_choice),
        .capacitor_code_i(capacitor_code),
        .dac_current_i(dac_current),
        .out_a_level_o(out_a_level),
        .out_b_level_o(out_b_level),
        .out_a_shutdown_o(out_a_shutdown),
        .out_b_shutdown_o(out_b_shutdown),
        .out_a_source_o(out_a_source),
        .out_b_source_o(out_b_source),
        .integer_mode_o(integer_mode),
        .modulator_order_o(modulator_order),
        .status_pin_high_drive_o(high_drive),
        .status_pin_o(status_pin),
        .quick_amplitude_cal_en_o(quick_amp),
        .quick_frequency_cal_en_o(quick_freq),
        .amplitude_step_o(amplitude_step),
        .frequency_step_o(frequency_step)
    );

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        logic [15:0] unused;
        host.xfer({1'b0, a, d}, 24, unused);
    endtask

    task automatic rd_check(input string name, input logic [6:0] a, input logic [15:0] exp);
        logic [15:0] got;
        host.xfer({1'b1, a, 16'h0000}, 24, got);
        check(name, exp, got);
    endtask

    // hang guard: a stuck run still reaches the verdict
    initial
    begin
        repeat (100000) @(posedge sys_clk);
        fail_count++;
        $display("[ERR] run length expected finish seen timeout");
        give_verdict();
    end

    initial
    begin
        logic [15:0] unused;
        cyc(3);
        rst = 1'b0;
        cyc(2);
        check("out_a_level", 16'h000f, 16'(out_a_level));
        check("out_b_level", 16'h0000, 16'(out_b_level));
        check("out_b_shutdown", 16'h0001, 16'(out_b_shutdown));
        check("out_a_shutdown", 16'h0000, 16'(out_a_shutdown));
        check("high_drive", 16'h0000, 16'(high_drive));
        check("quick_en", 16'h0000, 16'({quick_amp, quick_freq}));
        for (int i = 0; i < 7; i++)
            rd_check("reset word", rst_addr[i], rst_word[i]);
        // every modulator code, unnamed bits kept at zero defaults
        for (int i = 0; i < 8; i++)
        begin
            wr(OUTPUT_LEVEL_SHUTDOWN_MODULATOR, 16'h3f40 | 16'(i));
            exp_ord = (i >= 1 && i <= 4) ? 4'(1 << (i - 1)) : 4'h0;
            check("integer_mode", 16'(i == 0), 16'(integer_mode));
            check("modulator_order", 16'(exp_ord), 16'(modulator_order));
        end
        check("out_a_level", 16'h003f, 16'(out_a_level));
        check("out_a_shutdown", 16'h0001, 16'(out_a_shutdown));
        check("out_b_shutdown", 16'h0000, 16'(out_b_shutdown));
        // host uses only source codes 0 and 1
        wr(OUTPUT_A_SOURCE_B_LEVEL, 16'h0830);
        wr(OUTPUT_B_SOURCE, 16'h0001);
        check("out_a_source", 16'h0001, 16'(out_a_source));
        check("out_b_source", 16'h0001, 16'(out_b_source));
        check("out_b_level", 16'h0030, 16'(out_b_level));
        wr(OUTPUT_A_SOURCE_B_LEVEL, 16'h001f);
        check("out_a_source", 16'h0000, 16'(out_a_source));
        rd_check("level word", OUTPUT_A_SOURCE_B_LEVEL, 16'h001f);
        wr(STATUS_PIN_DRIVE, 16'h0020);
        check("high_drive", 16'h0001, 16'(high_drive));
        // a 23-bit frame must be dropped
        host.xfer({1'b0, STATUS_PIN_DRIVE, 16'h0000}, 23, unused);
        check("high_drive short", 16'h0001, 16'(high_drive));
        for (int en = 0; en < 4; en++)
        begin
            wr(FAST_CALIBRATION_CONFIG, 16'(en << 8) | 16'h00a9);
            check("quick_en", 16'(en), 16'({quick_amp, quick_freq}));
            check("amplitude_step", en[1] ? 16'h0005 : 16'h0000, 16'(amplitude_step));
            check("frequency_step", en[0] ? 16'h0009 : 16'h0000, 16'(frequency_step));
        end
        // lock indication selected, type one by default
        status_pin_select = 1'b1;
        for (int c = 0; c < 4; c++)
        begin
            tuning_lock = 2'(c);
            cyc(2);
            check("status_pin tune", 16'(c == 2), 16'(status_pin));
        end
        wr(LOCK_INDICATOR_CONFIG, 16'h0000);
        for (int c = 0; c < 2; c++)
        begin
            cal_done = c[0];
            cyc(2);
            check("status_pin cal", 16'(c), 16'(status_pin));
        end
        status_pin_select = 1'b0;
        cyc(2);
        check("status_pin off", 16'h0000, 16'(status_pin));
        core_choice = 3'h7;
        capacitor_code = 8'ha5;
        dac_current = 9'h1c3;
        tuning_lock = 2'h3;
        for (int pass = 0; pass < 2; pass++)
        begin
            rd_check("lock core", LOCK_AND_CORE_READBACK, 16'h06e0);
            rd_check("cap code", CAPACITOR_CODE_READBACK, 16'h00a5);
            rd_check("dac code", DAC_CURRENT_READBACK, 16'h01c3);
            wr(LOCK_AND_CORE_READBACK, 16'hffff);
            wr(CAPACITOR_CODE_READBACK, 16'hffff);
            wr(DAC_CURRENT_READBACK, 16'hffff);
        end
        rd_check("unmapped", 7'h50, 16'h0000);
        give_verdict();
    end
endmodule
`default_nettype wire
